// >>> dv/timers_and_interrupt_mux_test.sv
// self-checking bench for the timer, watchdog and interrupt mux
`timescale 1ns/1ps
`default_nettype none
module timers_and_interrupt_mux_test;
  import tmirq_pkg::*;
  logic clk = 0;
  logic rst = 1;
  tmirq_req_t req = '0;
  logic [10:0] fire = '0;
  logic [10:0] src;
  logic [15:0] rdata;
  tmirq_irq_t irq;
  logic sys_rst;
  int n_fail = 0;
  int checks_done = 0;
  int n;
  tmirq_top dut (.I_CLK_SYS(clk), .I_RST(rst), .I_REQ(req), .I_SRC(src), .O_RDATA(rdata), .O_IRQ(irq),
    .O_SYS_RST(sys_rst));
  tmirq_src_model peer (.i_clk(clk), .i_fire(fire), .o_src(src));
  // ----
  // tasks
  // ----
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d bad %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic pulse(input logic [10:0] m);
    @(posedge clk);
    fire <= m;
    @(posedge clk);
    fire <= 11'h000;
  endtask
  // what 99 waits for the reset pulse, else for that vector
  task automatic waitfor(input int lim, input int what);
    for (n = 1; n <= lim; n++) begin
      @(posedge clk);
      #1;
      if (what == 99 ? sys_rst === 1'b1 : irq.valid === 1'b1 && irq.vec === 4'(what)) begin
        checks_done++;
        return;
      end
    end
    chk(16'hdead, 16'(what));
    test_done();
  endtask
  // ----
  // tests
  // ----
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    rchk(TMIRQ_A_PRIO0, 16'h3210);
    rchk(TMIRQ_A_PRIO1, 16'h7654);
    rchk(TMIRQ_A_PRIO2, 16'h0a98);
    rchk(TMIRQ_A_IRQ_VEC, 16'h000f);
    rchk(4'hc, 16'h0000);
    for (int i = 0; i < 11; i++) begin
      pulse(11'(1) << i);
      if (i != 5 && i != 6) begin
        waitfor(5, i);
        wr(TMIRQ_A_IRQ_ACK, 16'(1) << i);
      end
    end
    rchk(TMIRQ_A_IRQ_PEND, 16'h0000);
    $display("sources done");
    pulse(11'h009);
    waitfor(5, 0);
    wr(TMIRQ_A_PRIO0, 16'h0123);
    waitfor(5, 3);
    wr(TMIRQ_A_IRQ_ACK, 16'h0008);
    waitfor(5, 0);
    rchk(TMIRQ_A_IRQ_PEND, 16'h0001);
    wr(TMIRQ_A_IRQ_ACK, 16'h0001);
    wr(TMIRQ_A_PRIO0, 16'h3210);
    $display("priority done");
    wr(TMIRQ_A_WDG_LOAD, 16'd30);
    rchk(TMIRQ_A_WDG_LOAD, 16'd30);
    repeat (3) begin
      repeat (25) @(posedge clk);
      wr(TMIRQ_A_WDG_KICK, 16'h0000);
    end
    rchk(TMIRQ_A_IRQ_PEND, 16'h0000);
    waitfor(40, 6);
    chk(16'(sys_rst), 16'h0000);
    rchk(TMIRQ_A_WDG_KICK, 16'h0001);
    waitfor(40, 99);
    wr(TMIRQ_A_WDG_LOAD, 16'hffff);
    wr(TMIRQ_A_WDG_KICK, 16'h0000);
    rchk(TMIRQ_A_WDG_CNT, 16'hfffe);
    rchk(TMIRQ_A_WDG_KICK, 16'h0000);
    wr(TMIRQ_A_IRQ_ACK, 16'h0040);
    $display("watchdog done");
    wr(TMIRQ_A_TMR_LOAD, 16'h0003);
    rchk(TMIRQ_A_TMR_LOAD, 16'h0003);
    wr(TMIRQ_A_TMR_CTRL, 16'h0021);
    waitfor(40, 5);
    wr(TMIRQ_A_IRQ_ACK, 16'h0020);
    repeat (40) @(posedge clk);
    rchk(TMIRQ_A_IRQ_PEND, 16'h0000);
    rchk(TMIRQ_A_TMR_CTRL, 16'h0020);
    rchk(TMIRQ_A_TMR_CNT, 16'h0003);
    wr(TMIRQ_A_TMR_CTRL, 16'h0023);
    waitfor(40, 5);
    wr(TMIRQ_A_IRQ_ACK, 16'h0020);
    // (3+1) ticks of four cycles, less the two taken by the ack
    waitfor(40, 5);
    chk(16'(n), 16'd14);
    $display("timer done");
    test_done();
  end
endmodule
bind tmirq_top tmirq_top_asserts #(.NSRC(NSRC)) chk_i (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_REQ(I_REQ),
  .I_SRC(I_SRC), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ), .O_SYS_RST(O_SYS_RST));
`default_nettype wire

// >>> dv/tmirq_src_model.sv
// event source model for the external interrupt lines
`timescale 1ns/1ps
`default_nettype none
module tmirq_src_model (
  input wire logic i_clk,
  input wire logic [10:0] i_fire,
  output logic [10:0] o_src = 11'h000
);
  // ----
  // one-cycle events, launched just after the edge
  // ----
  always @(posedge i_clk) begin
    o_src <= i_fire;
  end
endmodule
`default_nettype wire

// >>> dv/tmirq_top_asserts.sv
// port checker for the timer, watchdog and interrupt mux
`timescale 1ns/1ps
`default_nettype none
module tmirq_top_asserts
  import tmirq_pkg::*;
#(
  parameter int unsigned NSRC = 11
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire tmirq_pkg::tmirq_req_t I_REQ,
  input wire logic [tmirq_pkg::TMIRQ_NSRC-1:0] I_SRC,
  input wire logic [tmirq_pkg::TMIRQ_DW-1:0] O_RDATA,
  input wire tmirq_pkg::tmirq_irq_t O_IRQ,
  input wire logic O_SYS_RST
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  vec_none_a: assert property (!O_IRQ.valid |-> O_IRQ.vec == TMIRQ_NONE_VEC)
    else $error("vector without pending flag");
  vec_range_a: assert property (O_IRQ.valid |-> O_IRQ.vec < 4'hb)
    else $error("vector out of range");
  rst_pulse_a: assert property (O_SYS_RST |=> !O_SYS_RST)
    else $error("system reset longer than one cycle");
  wdg_irq_a: assert property (O_SYS_RST |=> O_IRQ.valid)
    else $error("system reset without interrupt");
  flag_hold_a: assert property ($fell(O_IRQ.valid) |->
    $past(I_REQ.wr, 2) && $past(I_REQ.addr, 2) == TMIRQ_A_IRQ_ACK) else $error("flag lost without ack");
  // internal timer and watchdog lines are masked out
  src_flag_a: assert property (|($past(I_SRC, 2) & 11'h79f) |-> O_IRQ.valid)
    else $error("source event not pending");
  rd_idle_a: assert property (!$past(I_REQ.rd) |-> O_RDATA == 16'h0000)
    else $error("read data outside read slot");
  unmapped_a: assert property ($past(I_REQ.rd) && $past(I_REQ.addr) > 4'hb |-> O_RDATA == 16'h0000)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// >>> include/tmirq_pkg.sv
// package for the timer, watchdog and interrupt mux block
package tmirq_pkg;
  localparam int unsigned TMIRQ_AW = 4;
  localparam int unsigned TMIRQ_DW = 16;
  localparam int unsigned TMIRQ_NSRC = 11;
  localparam int unsigned TMIRQ_TMR_W = 12;
  localparam int unsigned TMIRQ_PRE_W = 3;
  localparam int unsigned TMIRQ_WDG_W = 16;
  localparam int unsigned TMIRQ_VEC_W = 4;
  // register offsets
  localparam logic [3:0] TMIRQ_A_TMR_CTRL = 4'h0;
  localparam logic [3:0] TMIRQ_A_TMR_LOAD = 4'h1;
  localparam logic [3:0] TMIRQ_A_TMR_CNT = 4'h2;
  localparam logic [3:0] TMIRQ_A_WDG_LOAD = 4'h3;
  localparam logic [3:0] TMIRQ_A_WDG_KICK = 4'h4;
  localparam logic [3:0] TMIRQ_A_WDG_CNT = 4'h5;
  localparam logic [3:0] TMIRQ_A_IRQ_PEND = 4'h6;
  localparam logic [3:0] TMIRQ_A_IRQ_ACK = 4'h7;
  localparam logic [3:0] TMIRQ_A_IRQ_VEC = 4'h8;
  localparam logic [3:0] TMIRQ_A_PRIO0 = 4'h9;
  localparam logic [3:0] TMIRQ_A_PRIO1 = 4'ha;
  localparam logic [3:0] TMIRQ_A_PRIO2 = 4'hb;
  // timer control fields
  localparam int unsigned TMIRQ_B_START = 0;
  localparam int unsigned TMIRQ_B_CONT = 1;
  localparam int unsigned TMIRQ_B_PRE_LO = 4;
  // source indices
  localparam int unsigned TMIRQ_S_TMR = 5;
  localparam int unsigned TMIRQ_S_WDG = 6;
  localparam logic [15:0] TMIRQ_WDG_RST = 16'hffff;
  localparam logic [11:0] TMIRQ_TMR_RST = 12'hfff;
  localparam logic [3:0] TMIRQ_NONE_VEC = 4'hf;
  localparam logic [2:0] TMIRQ_PRE_ONE = 3'h1;
  // reset priority table: source i sits at rank i
  localparam logic [15:0] TMIRQ_PRIO0_RST = 16'h3210;
  localparam logic [15:0] TMIRQ_PRIO1_RST = 16'h7654;
  localparam logic [15:0] TMIRQ_PRIO2_RST = 16'h0a98;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tmirq_req_t;
  typedef struct packed {
    logic valid;
    logic [3:0] vec;
  } tmirq_irq_t;
endpackage

// >>> src/tmirq_top.sv
// timer, watchdog and prioritized interrupt mux
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tmirq_top
  import tmirq_pkg::*;
#(
  parameter int unsigned NSRC = tmirq_pkg::TMIRQ_NSRC
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire tmirq_pkg::tmirq_req_t I_REQ,
  input wire logic [tmirq_pkg::TMIRQ_NSRC-1:0] I_SRC,
  output logic [tmirq_pkg::TMIRQ_DW-1:0] O_RDATA,
  output tmirq_pkg::tmirq_irq_t O_IRQ,
  output logic O_SYS_RST
);
  import tmirq_pkg::*;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // one strobe per register; an unmapped or read-only offset matches none
  wire logic wr_tctl = I_REQ.wr && (I_REQ.addr == TMIRQ_A_TMR_CTRL);
  wire logic wr_tload = I_REQ.wr && (I_REQ.addr == TMIRQ_A_TMR_LOAD);
  wire logic wr_wload = I_REQ.wr && (I_REQ.addr == TMIRQ_A_WDG_LOAD);
  wire logic wr_kick = I_REQ.wr && (I_REQ.addr == TMIRQ_A_WDG_KICK);
  wire logic wr_ack = I_REQ.wr && (I_REQ.addr == TMIRQ_A_IRQ_ACK);
  wire logic wr_p0 = I_REQ.wr && (I_REQ.addr == TMIRQ_A_PRIO0);
  wire logic wr_p1 = I_REQ.wr && (I_REQ.addr == TMIRQ_A_PRIO1);
  wire logic wr_p2 = I_REQ.wr && (I_REQ.addr == TMIRQ_A_PRIO2);

  // ----------------------------------------
  // write data fields
  // ----------------------------------------
  wire logic [TMIRQ_PRE_W-1:0] wr_pre = I_REQ.wdata[TMIRQ_B_PRE_LO +: TMIRQ_PRE_W];
  wire logic wr_cont = I_REQ.wdata[TMIRQ_B_CONT];
  wire logic wr_start = I_REQ.wdata[TMIRQ_B_START];
  wire logic [TMIRQ_TMR_W-1:0] wr_tval = I_REQ.wdata[TMIRQ_TMR_W-1:0];
  wire logic [NSRC-1:0] wr_mask = I_REQ.wdata[NSRC-1:0];

  // ----------------------------------------
  // general timer
  // ----------------------------------------
  logic [TMIRQ_TMR_W-1:0] tload_r;
  logic [TMIRQ_TMR_W-1:0] tcnt_r;
  logic [TMIRQ_TMR_W-1:0] tcnt_nxt;
  logic [TMIRQ_PRE_W-1:0] pre_sel_r;
  logic [6:0] pre_cnt_r;
  logic [6:0] pre_cnt_nxt;
  logic cont_r;
  logic trun_r;
  logic trun_nxt;

  // ----------------------------------------
  // timer start
  // ----------------------------------------
  // a start write restarts the count even while it runs
  wire logic tstart = wr_tctl && wr_start;

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  // divide by 2**code: tick when low code bits of the prescale counter are all ones; a tick or start clears it
  wire logic [6:0] pre_mask = 7'((8'h01 << pre_sel_r) - 8'h01);
  wire logic tick = ((pre_cnt_r & pre_mask) == pre_mask);
  // restart clears the phase so the first period is a full one
  assign pre_cnt_nxt = (tstart || tick) ? '0 : pre_cnt_r + 7'h01;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
    end
  end

  // ----------------------------------------
  // timer configuration
  // ----------------------------------------
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      pre_sel_r <= '0;
      cont_r <= 1'b0;
      tload_r <= TMIRQ_TMR_RST;
    end else begin
      if (wr_tctl) begin
        cont_r <= wr_cont;
        pre_sel_r <= wr_pre;
      end
      if (wr_tload) begin
        // upper data bits are dropped: the count is only twelve bits wide
        tload_r <= wr_tval;
      end
    end
  end

  // ----------------------------------------
  // timer down counter
  // ----------------------------------------
  // zero is the last tick, so a load of n gives n+1 ticks per period
  wire logic tzero = (tcnt_r == '0);
  wire logic texp = trun_r && tick && tzero;

  always_comb begin
    tcnt_nxt = tcnt_r;
    trun_nxt = trun_r;
    if (tstart) begin
      tcnt_nxt = tload_r;
      trun_nxt = 1'b1;
    end else if (texp) begin
      tcnt_nxt = tload_r;
      trun_nxt = cont_r;
    end else if (trun_r && tick) begin
      tcnt_nxt = tcnt_r - 12'h001;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      tcnt_r <= '0;
      trun_r <= 1'b0;
    end else begin
      tcnt_r <= tcnt_nxt;
      trun_r <= trun_nxt;
    end
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // no enable bit exists on purpose: it cannot be stopped
  logic [TMIRQ_WDG_W-1:0] wload_r;
  logic [TMIRQ_WDG_W-1:0] wcnt_r;
  logic [TMIRQ_WDG_W-1:0] wcnt_nxt;
  logic wmiss_r;
  logic wmiss_nxt;
  logic sys_rst_r;
  logic sys_rst_nxt;

  // ----------------------------------------
  // watchdog period
  // ----------------------------------------
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      wload_r <= TMIRQ_WDG_RST;
    end else if (wr_wload) begin
      // a new period takes effect at the next kick or expiry
      wload_r <= I_REQ.wdata;
    end
  end

  // ----------------------------------------
  // watchdog counter
  // ----------------------------------------
  wire logic wexp = (wcnt_r == '0);
  // a kick in the expiry cycle wins, so a late but valid kick is honoured
  always_comb begin
    wcnt_nxt = wcnt_r - 16'h0001;
    wmiss_nxt = wmiss_r;
    sys_rst_nxt = 1'b0;
    if (wr_kick) begin
      wcnt_nxt = wload_r;
      wmiss_nxt = 1'b0;
    end else if (wexp) begin
      wcnt_nxt = wload_r;
      wmiss_nxt = 1'b1;
      sys_rst_nxt = wmiss_r;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      wcnt_r <= TMIRQ_WDG_RST;
      wmiss_r <= 1'b0;
      sys_rst_r <= 1'b0;
    end else begin
      wcnt_r <= wcnt_nxt;
      wmiss_r <= wmiss_nxt;
      sys_rst_r <= sys_rst_nxt;
    end
  end
  assign O_SYS_RST = sys_rst_r;

  // ----------------------------------------
  // interrupt controller
  // ----------------------------------------
  // ----------------------------------------
  // source events
  // ----------------------------------------
  // source lines: 0 filterbank_done_irq, 1 audio block, 2 pcm, 3 serial rx,
  // 4 serial tx, 5 general_timer_irq, 6 watchdog, 7 spi, 8 two_wire_slave_irq,
  // 9 aux_register_receive_irq, 10 aux_register_transmit_irq
  wire logic tmr_ev = texp;
  // a kick in the expiry cycle cancels the watchdog event
  wire logic wdg_ev = wexp && !wr_kick;
  logic [NSRC-1:0] ev;
  always_comb begin
    ev = I_SRC;
    ev[TMIRQ_S_TMR] = tmr_ev;
    ev[TMIRQ_S_WDG] = wdg_ev;
  end

  // ----------------------------------------
  // pending flags
  // ----------------------------------------
  logic [NSRC-1:0] pend_r;
  wire logic [NSRC-1:0] pend_clr = wr_ack ? wr_mask : '0;
  // set wins over a same-cycle acknowledge
  wire logic [NSRC-1:0] pend_nxt = (pend_r & ~pend_clr) | ev;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // ----------------------------------------
  // priority table
  // ----------------------------------------
  // four ranks per register, one nibble each
  logic [TMIRQ_DW-1:0] prio_r [3];
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      prio_r[0] <= TMIRQ_PRIO0_RST;
      prio_r[1] <= TMIRQ_PRIO1_RST;
      prio_r[2] <= TMIRQ_PRIO2_RST;
    end else begin
      if (wr_p0) begin
        prio_r[0] <= I_REQ.wdata;
      end
      if (wr_p1) begin
        prio_r[1] <= I_REQ.wdata;
      end
      if (wr_p2) begin
        prio_r[2] <= I_REQ.wdata;
      end
    end
  end

  // ----------------------------------------
  // priority select
  // ----------------------------------------
  // slot k names the source of rank k; slot 0 is the highest
  // an out-of-range slot is skipped, so a bad table cannot pick a ghost source
  logic [TMIRQ_VEC_W-1:0] rank_src [NSRC];
  logic [NSRC-1:0] rank_hit;
  logic [NSRC:0] rank_seen;
  logic [TMIRQ_VEC_W-1:0] rank_pick [NSRC+1];

  assign rank_seen[0] = 1'b0;
  assign rank_pick[0] = TMIRQ_NONE_VEC;
  for (genvar k = 0; k < NSRC; k++) begin : g_rank
    assign rank_src[k] = prio_r[k/4][(k%4)*4 +: 4];
    assign rank_hit[k] = (rank_src[k] < 4'(NSRC)) && pend_r[rank_src[k]];
    assign rank_seen[k+1] = rank_seen[k] || rank_hit[k];
    assign rank_pick[k+1] = (!rank_seen[k] && rank_hit[k]) ? rank_src[k] : rank_pick[k];
  end
  wire logic found = rank_seen[NSRC];
  wire logic [TMIRQ_VEC_W-1:0] pick = rank_pick[NSRC];

  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  // registered so the vector never glitches while the core reads it
  tmirq_irq_t irq_r;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      irq_r <= '{valid: 1'b0, vec: TMIRQ_NONE_VEC};
    end else begin
      irq_r <= '{valid: found, vec: pick};
    end
  end
  assign O_IRQ = irq_r;

  // ----------------------------------------
  // read back
  // ----------------------------------------
  // unused upper bits read as zero
  wire logic [TMIRQ_DW-1:0] tctl_word = 16'({pre_sel_r, 2'b00, cont_r, trun_r});
  wire logic [TMIRQ_DW-1:0] vec_word = 16'({irq_r.valid, 11'h000, irq_r.vec});
  wire logic [TMIRQ_DW-1:0] rd_tload = 16'(tload_r);
  wire logic [TMIRQ_DW-1:0] rd_tcnt = 16'(tcnt_r);
  wire logic [TMIRQ_DW-1:0] rd_wmiss = 16'(wmiss_r);
  wire logic [TMIRQ_DW-1:0] rd_pend = 16'(pend_r);

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // an unmapped offset reads as zero
  logic [TMIRQ_DW-1:0] rmux;
  always_comb begin
    unique case (I_REQ.addr)
      TMIRQ_A_TMR_CTRL: rmux = tctl_word;
      TMIRQ_A_TMR_LOAD: rmux = rd_tload;
      TMIRQ_A_TMR_CNT: rmux = rd_tcnt;
      TMIRQ_A_WDG_LOAD: rmux = wload_r;
      TMIRQ_A_WDG_CNT: rmux = wcnt_r;
      TMIRQ_A_WDG_KICK: rmux = rd_wmiss;
      TMIRQ_A_IRQ_PEND: rmux = rd_pend;
      TMIRQ_A_IRQ_VEC: rmux = vec_word;
      TMIRQ_A_PRIO0: rmux = prio_r[0];
      TMIRQ_A_PRIO1: rmux = prio_r[1];
      TMIRQ_A_PRIO2: rmux = prio_r[2];
      default: rmux = '0;
    endcase
  end

  // ----------------------------------------
  // read register
  // ----------------------------------------
  // zero outside the read slot, so read buses of several blocks can be or-ed
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      O_RDATA <= '0;
    end else begin
      O_RDATA <= I_REQ.rd ? rmux : '0;
    end
  end
endmodule
`default_nettype wire
